//--- tw_pkg.sv
// constants, register map and types for the 16-bit timer waveform block
package tw_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL_A = 8'h2F;
  localparam logic [7:0] IDX_CTRL_B = 8'h2E;
  localparam logic [7:0] IDX_COUNT = 8'h2C;
  localparam logic [7:0] IDX_CMP_A = 8'h2A;
  localparam logic [7:0] IDX_CMP_B = 8'h28;
  localparam logic [7:0] IDX_CAPTURE = 8'h26;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h31;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h32;

  // timer_output_mode_ctrl fields
  localparam int CHA_MODE_LSB = 6;
  localparam int CHB_MODE_LSB = 4;
  localparam int WAVE_LOW_LSB = 0;
  localparam logic [7:0] CTRL_A_WRITE_MASK = 8'hF3;
  localparam logic [7:0] CTRL_A_RESET = 8'h00;
  // second control register fields
  localparam int WAVE_HIGH_LSB = 3;
  localparam int TICK_SEL_LSB = 0;
  localparam logic [4:0] CTRL_B_RESET = 5'h00;

  // interrupt status bits
  localparam int ST_OVERFLOW = 0;
  localparam int ST_MATCH_A = 1;
  localparam int ST_MATCH_B = 2;

  // counter limits
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // waveform modes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_PC_8 = 4'h1;
  localparam logic [3:0] MODE_PC_9 = 4'h2;
  localparam logic [3:0] MODE_PC_10 = 4'h3;
  localparam logic [3:0] MODE_CTC_CMP = 4'h4;
  localparam logic [3:0] MODE_FAST_8 = 4'h5;
  localparam logic [3:0] MODE_FAST_9 = 4'h6;
  localparam logic [3:0] MODE_FAST_10 = 4'h7;
  localparam logic [3:0] MODE_PFC_CAP = 4'h8;
  localparam logic [3:0] MODE_PFC_CMP = 4'h9;
  localparam logic [3:0] MODE_PC_CAP = 4'hA;
  localparam logic [3:0] MODE_PC_CMP = 4'hB;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_RESERVED = 4'hD;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_CMP = 4'hF;

  // output-mode codes
  localparam logic [1:0] OM_OFF = 2'h0;
  localparam logic [1:0] OM_TOGGLE = 2'h1;
  localparam logic [1:0] OM_CLEAR = 2'h2;
  localparam logic [1:0] OM_SET = 2'h3;

  // tick source select codes and prescaler masks
  localparam logic [2:0] TS_STOP = 3'h0;
  localparam logic [2:0] TS_DIV1 = 3'h1;
  localparam logic [2:0] TS_DIV8 = 3'h2;
  localparam logic [2:0] TS_DIV64 = 3'h3;
  localparam logic [2:0] TS_DIV256 = 3'h4;
  localparam logic [2:0] TS_DIV1024 = 3'h5;
  localparam logic [2:0] TS_PIN_FALL = 3'h6;
  localparam logic [2:0] TS_PIN_RISE = 3'h7;
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  typedef enum logic [3:0] {
    FAM_NORMAL = 4'b0001,
    FAM_FAST = 4'b0010,
    FAM_DUAL_TOP = 4'b0100,
    FAM_DUAL_BOT = 4'b1000
  } tw_family_type;

endpackage : tw_pkg

//--- tw_tick_if.sv
// tick source select and timer tick enable between timer core and tick generator
`timescale 1ns/1ns
`default_nettype none
interface tw_tick_if;
  logic [2:0] tickSelect;
  logic timerTick;
  modport gen (input tickSelect, output timerTick);
  modport user (output tickSelect, input timerTick);
endinterface : tw_tick_if
`default_nettype wire

//--- tw_tick_gen.sv
// prescaler and external tick pin edge detector producing the timer tick enable
`timescale 1ns/1ns
`default_nettype none
module tw_tick_gen
  import tw_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic extTickPin,
  tw_tick_if.gen tickBus
);

  typedef struct packed {
    logic [9:0] preCount;
    logic pinS1;
    logic pinS2;
    logic pinS3;
    logic pinLevel;
  } tw_gen_state_type;

  tw_gen_state_type state;
  tw_gen_state_type next_state;
  logic pinRise;
  logic pinFall;

  // a pin change counts once the second and third stages agree
  assign pinRise = (state.pinS2 == state.pinS3) && state.pinS3 && !state.pinLevel;
  assign pinFall = (state.pinS2 == state.pinS3) && !state.pinS3 && state.pinLevel;

  always_comb begin
    next_state = state;
    next_state.preCount = state.preCount + 10'h001;
    next_state.pinS1 = extTickPin;
    next_state.pinS2 = state.pinS1;
    next_state.pinS3 = state.pinS2;
    if (state.pinS2 == state.pinS3) begin
      next_state.pinLevel = state.pinS3;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    case (tickBus.tickSelect)
      TS_STOP: tickBus.timerTick = 1'b0;
      TS_DIV1: tickBus.timerTick = 1'b1;
      TS_DIV8: tickBus.timerTick = (state.preCount & DIV8_MASK) == DIV8_MASK;
      TS_DIV64: tickBus.timerTick = (state.preCount & DIV64_MASK) == DIV64_MASK;
      TS_DIV256: tickBus.timerTick = (state.preCount & DIV256_MASK) == DIV256_MASK;
      TS_DIV1024: tickBus.timerTick = (state.preCount & DIV1024_MASK) == DIV1024_MASK;
      TS_PIN_FALL: tickBus.timerTick = pinFall;
      TS_PIN_RISE: tickBus.timerTick = pinRise;
      default: tickBus.timerTick = 1'b0;
    endcase
  end

endmodule : tw_tick_gen
`default_nettype wire

//--- tw_timer.sv
// 16-bit timer with waveform modes, two compare outputs and APB registers
// Contract
// - everything runs on core_clk; the timer tick is only an enable
// - nonzero output-mode code hands that channel's pin to the compare output, except code 01 in PWM modes with mode bit 3 clear
// - non-PWM codes: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM code 01: off unless mode bit 3; then A toggles, B reserved
// - fast PWM 10 clears on match, sets at bottom; 11 the inverse
// - fast PWM compare equal TOP with high code bit: match ignored, bottom acts
// - dual-slope 10 clears on up match, sets on down match; 11 inverse
// - dual-slope code 01: off unless mode bit 3; then A toggles, B reserved
// - waveform mode is two low bits here plus two high bits in second register
// - mode 0 tops at 0xFFFF, CLEAR_ON_MATCH_MODE 4/12 top from compare A/capture; immediate
// - phase correct 1,2,3,10,11: update at TOP, overflow at BOTTOM
// - fast PWM 5,6,7,14,15: update at BOTTOM, overflow at TOP
// - phase-frequency correct 8,9: update and overflow both at BOTTOM
// - bottom events use the same tick timing as top events
// - tick source: stopped, divide 1/8/64/256/1024, or pin edge
// - dual-slope counts bottom to TOP and back, holding TOP one tick
// - a counter write blocks every compare match on the next tick
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
module tw_timer
  import tw_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [9:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic extTickPin,
  output logic chanAWaveOut,
  output logic chanAPinOwned,
  output logic chanBWaveOut,
  output logic chanBPinOwned,
  output logic irq
);

  typedef struct packed {
    logic [7:0] ctrlA;
    logic [4:0] ctrlB;
    logic [15:0] count;
    logic countUp;
    logic [15:0] cmpBufA;
    logic [15:0] cmpBufB;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [15:0] capture;
    logic [2:0] status;
    logic [2:0] enable;
    logic waveA;
    logic waveB;
    logic blockMatch;
    logic [31:0] rdata;
  } tw_state_type;

  tw_state_type state;
  tw_state_type next_state;
  tw_tick_if tickBus ();

  logic [3:0] waveMode;
  logic [1:0] codeA;
  logic [1:0] codeB;
  tw_family_type family;
  logic [15:0] topValue;
  logic tick;
  logic atTop;
  logic atBottom;
  logic matchA;
  logic matchB;
  logic updateNow;
  logic overflowNow;
  logic mapped;
  logic accessWrite;
  logic setupPhase;

  function automatic tw_family_type tw_family(input logic [3:0] mode);
    case (mode)
      MODE_FAST_8, MODE_FAST_9, MODE_FAST_10, MODE_FAST_CAP, MODE_FAST_CMP: begin
        tw_family = FAM_FAST;
      end
      MODE_PC_8, MODE_PC_9, MODE_PC_10, MODE_PC_CAP, MODE_PC_CMP: begin
        tw_family = FAM_DUAL_TOP;
      end
      MODE_PFC_CAP, MODE_PFC_CMP: tw_family = FAM_DUAL_BOT;
      default: tw_family = FAM_NORMAL;
    endcase
  endfunction : tw_family

  function automatic logic [15:0] tw_top(input logic [3:0] mode, input logic [15:0] cmp,
                                         input logic [15:0] cap);
    case (mode)
      MODE_PC_8, MODE_FAST_8: tw_top = TOP_8BIT;
      MODE_PC_9, MODE_FAST_9: tw_top = TOP_9BIT;
      MODE_PC_10, MODE_FAST_10: tw_top = TOP_10BIT;
      MODE_CTC_CMP, MODE_PFC_CMP, MODE_PC_CMP, MODE_FAST_CMP: tw_top = cmp;
      MODE_CTC_CAP, MODE_PFC_CAP, MODE_PC_CAP, MODE_FAST_CAP: tw_top = cap;
      default: tw_top = CNT_MAX;
    endcase
  endfunction : tw_top

  // next level of one compare output
  function automatic logic tw_wave_step(input tw_family_type fam, input logic [1:0] code,
                                        input logic isChanA, input logic bit3,
                                        input logic match, input logic bottom,
                                        input logic up, input logic cmpAtTop,
                                        input logic cur);
    logic v;
    logic pwmToggle;
    v = cur;
    pwmToggle = bit3 && isChanA;
    case (fam)
      FAM_NORMAL: begin
        if (match) begin
          case (code)
            OM_TOGGLE: v = !cur;
            OM_CLEAR: v = 1'b0;
            OM_SET: v = 1'b1;
            default: v = cur;
          endcase
        end
      end
      FAM_FAST: begin
        if (bottom && code == OM_CLEAR) begin
          v = 1'b1;
        end
        if (bottom && code == OM_SET) begin
          v = 1'b0;
        end
        if (match && !(code[1] && cmpAtTop)) begin
          case (code)
            OM_TOGGLE: v = pwmToggle ? !cur : cur;
            OM_CLEAR: v = 1'b0;
            OM_SET: v = 1'b1;
            default: v = cur;
          endcase
        end
      end
      FAM_DUAL_TOP, FAM_DUAL_BOT: begin
        if (match) begin
          case (code)
            OM_TOGGLE: v = pwmToggle ? !cur : cur;
            OM_CLEAR: v = !up;
            OM_SET: v = up;
            default: v = cur;
          endcase
        end
      end
      default: v = cur;
    endcase
    return v;
  endfunction : tw_wave_step

  tw_tick_gen tickGen (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .extTickPin(extTickPin),
    .tickBus(tickBus.gen)
  );

  assign tickBus.tickSelect = state.ctrlB[TICK_SEL_LSB +: 3];
  assign tick = tickBus.timerTick;
  assign waveMode = {state.ctrlB[WAVE_HIGH_LSB +: 2], state.ctrlA[WAVE_LOW_LSB +: 2]};
  assign codeA = state.ctrlA[CHA_MODE_LSB +: 2];
  assign codeB = state.ctrlA[CHB_MODE_LSB +: 2];
  assign family = tw_family(waveMode);
  assign topValue = tw_top(waveMode, state.cmpA, state.capture);
  assign atTop = state.count == topValue;
  assign atBottom = state.count == CNT_BOTTOM;
  assign matchA = tick && !state.blockMatch && state.count == state.cmpA;
  assign matchB = tick && !state.blockMatch && state.count == state.cmpB;

  // update and overflow points, each seen on the tick that holds the value
  always_comb begin
    case (family)
      FAM_FAST: begin
        updateNow = tick && atBottom;
        overflowNow = tick && atTop;
      end
      FAM_DUAL_TOP: begin
        updateNow = tick && atTop && state.countUp;
        overflowNow = tick && atBottom && !state.countUp;
      end
      FAM_DUAL_BOT: begin
        updateNow = tick && atBottom && !state.countUp;
        overflowNow = tick && atBottom && !state.countUp;
      end
      default: begin
        updateNow = 1'b0;
        overflowNow = tick && state.count == CNT_MAX;
      end
    endcase
  end

  // register decode
  assign setupPhase = psel && !penable;
  assign accessWrite = psel && penable && pwrite && mapped;
  always_comb begin
    mapped = paddr[1:0] == 2'h0;
    case (paddr[9:2])
      IDX_CTRL_A, IDX_CTRL_B, IDX_COUNT, IDX_CMP_A, IDX_CMP_B, IDX_CAPTURE,
      IDX_IRQ_STATUS, IDX_IRQ_CLEAR, IDX_IRQ_ENABLE: mapped = mapped;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    // counting sequence
    if (tick) begin
      next_state.blockMatch = 1'b0;
      if (family == FAM_DUAL_TOP || family == FAM_DUAL_BOT) begin
        if (state.countUp) begin
          if (state.count >= topValue) begin
            next_state.countUp = 1'b0;
            next_state.count = (topValue == CNT_BOTTOM) ? CNT_BOTTOM : state.count - 16'h0001;
          end else begin
            next_state.count = state.count + 16'h0001;
          end
        end else if (atBottom) begin
          next_state.countUp = 1'b1;
          next_state.count = (topValue == CNT_BOTTOM) ? CNT_BOTTOM : 16'h0001;
        end else begin
          next_state.count = state.count - 16'h0001;
        end
      end else begin
        next_state.countUp = 1'b1;
        next_state.count = (state.count >= topValue) ? CNT_BOTTOM : state.count + 16'h0001;
      end
    end
    if (updateNow) begin
      next_state.cmpA = state.cmpBufA;
      next_state.cmpB = state.cmpBufB;
    end
    next_state.waveA = tw_wave_step(family, codeA, 1'b1, waveMode[3], matchA,
                                    tick && atBottom, state.countUp,
                                    state.cmpA == topValue, state.waveA);
    next_state.waveB = tw_wave_step(family, codeB, 1'b0, waveMode[3], matchB,
                                    tick && atBottom, state.countUp,
                                    state.cmpB == topValue, state.waveB);
    // read data captured in the setup cycle
    if (setupPhase) begin
      case (paddr[9:2])
        IDX_CTRL_A: next_state.rdata = {24'h000000, state.ctrlA};
        IDX_CTRL_B: next_state.rdata = {27'h0000000, state.ctrlB};
        IDX_COUNT: next_state.rdata = {16'h0000, state.count};
        IDX_CMP_A: next_state.rdata = {16'h0000, state.cmpBufA};
        IDX_CMP_B: next_state.rdata = {16'h0000, state.cmpBufB};
        IDX_CAPTURE: next_state.rdata = {16'h0000, state.capture};
        IDX_IRQ_STATUS: next_state.rdata = {29'h00000000, state.status};
        IDX_IRQ_ENABLE: next_state.rdata = {29'h00000000, state.enable};
        default: next_state.rdata = 32'h00000000;
      endcase
    end
    // register writes
    if (accessWrite) begin
      case (paddr[9:2])
        IDX_CTRL_A: next_state.ctrlA = pwdata[7:0] & CTRL_A_WRITE_MASK;
        IDX_CTRL_B: next_state.ctrlB = pwdata[4:0];
        IDX_COUNT: begin
          next_state.count = pwdata[15:0];
          next_state.blockMatch = 1'b1;
        end
        IDX_CMP_A: begin
          next_state.cmpBufA = pwdata[15:0];
          if (family == FAM_NORMAL) begin
            next_state.cmpA = pwdata[15:0];
          end
        end
        IDX_CMP_B: begin
          next_state.cmpBufB = pwdata[15:0];
          if (family == FAM_NORMAL) begin
            next_state.cmpB = pwdata[15:0];
          end
        end
        IDX_CAPTURE: next_state.capture = pwdata[15:0];
        IDX_IRQ_CLEAR: next_state.status = state.status & ~pwdata[2:0];
        IDX_IRQ_ENABLE: next_state.enable = pwdata[2:0];
        default: next_state.enable = state.enable;
      endcase
    end
    // events win over a clear in the same cycle
    if (overflowNow) begin
      next_state.status[ST_OVERFLOW] = 1'b1;
    end
    if (matchA) begin
      next_state.status[ST_MATCH_A] = 1'b1;
    end
    if (matchB) begin
      next_state.status[ST_MATCH_B] = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state <= '0;
      state.ctrlA <= CTRL_A_RESET;
      state.ctrlB <= CTRL_B_RESET;
      state.countUp <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = state.rdata;
  assign chanAWaveOut = state.waveA;
  assign chanBWaveOut = state.waveB;
  // direction bit set outside enables the driver; family[0] is non-PWM
  assign chanAPinOwned = codeA[1] || (codeA[0] && (family[0] || waveMode[3]));
  assign chanBPinOwned = codeB[1] || (codeB[0] && (family[0] || waveMode[3]));
  assign irq = |(state.status & state.enable);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  stopped_no_count_a: assert property (
    tickBus.tickSelect == TS_STOP && !accessWrite |=> $stable(state.count))
    else $error("counter moved while stopped");

  count_hold_a: assert property (
    !tick && !accessWrite |=> $stable(state.count) && $stable(state.waveA))
    else $error("counter or output changed without a tick");

  pin_owner_a: assert property (
    (codeA[1] || codeA == OM_OFF) |-> chanAPinOwned == codeA[1])
    else $error("pin ownership does not follow output mode");

  nonpwm_clear_a: assert property (
    family == FAM_NORMAL && matchA && codeA == OM_CLEAR |=> !chanAWaveOut)
    else $error("non-PWM clear on match failed");

  fast_bottom_set_a: assert property (
    family == FAM_FAST && tick && atBottom && codeA == OM_CLEAR && !matchA
    |=> chanAWaveOut)
    else $error("fast PWM did not set output at bottom");

  fast_top_ignore_a: assert property (
    family == FAM_FAST && matchA && codeA == OM_SET && state.cmpA == topValue
    && !atBottom |=> $stable(chanAWaveOut))
    else $error("fast PWM acted on a match at TOP");

  dual_up_clear_a: assert property (
    (family == FAM_DUAL_TOP || family == FAM_DUAL_BOT) && matchA && codeA == OM_CLEAR
    |=> chanAWaveOut == !$past(state.countUp))
    else $error("dual-slope output wrong for direction");

  chan_b_reserved_a: assert property (
    family != FAM_NORMAL && codeB == OM_TOGGLE |=> $stable(chanBWaveOut))
    else $error("channel B toggled in a PWM mode");

  dual_turn_a: assert property (
    (family == FAM_DUAL_TOP || family == FAM_DUAL_BOT) && tick && atTop && state.countUp
    && topValue != CNT_BOTTOM && !accessWrite ##1 tick && !accessWrite
    |=> state.count == $past(topValue, 2) - 16'h0002)
    else $error("dual-slope did not hold TOP for one tick");

  normal_wrap_a: assert property (
    waveMode == MODE_NORMAL && tick && state.count == CNT_MAX && !accessWrite
    |=> state.count == CNT_BOTTOM && state.status[ST_OVERFLOW])
    else $error("normal mode did not wrap with overflow");

  pfc_update_a: assert property (
    family == FAM_DUAL_BOT && state.cmpA != state.cmpBufA && !updateNow |=> $stable(state.cmpA))
    else $error("compare A changed away from bottom");

  write_block_a: assert property (
    accessWrite && paddr[9:2] == IDX_COUNT |=> !matchA && !matchB)
    else $error("compare match not blocked after counter write");

  fast_pwm_c: cover property (family == FAM_FAST && matchA ##[1:300] tick && atBottom);
  dual_turn_c: cover property (family == FAM_DUAL_TOP && tick && atTop && state.countUp);
  irq_c: cover property (irq);
  block_c: cover property (state.blockMatch && tick && state.count == state.cmpA);

endmodule : tw_timer
`default_nettype wire

//--- tw_pin_load.sv
// external load on one compare output pin, behind a port direction bit and pull-up
`timescale 1ns/1ns
`default_nettype none
module tw_pin_load (
  input wire logic owned,
  input wire logic wave,
  input wire logic dirOut,
  output logic pinLevel
);
  // driver only enabled with direction set, else the pull-up holds the pin
  assign pinLevel = (owned && dirOut) ? wave : 1'b1;
endmodule : tw_pin_load
`default_nettype wire

//--- timer16_waveform_mode_control_tb.sv
// self-checking bench for the timer waveform block
`timescale 1ns/1ns
`default_nettype none
module timer16_waveform_mode_control_tb
  import tw_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [9:0] paddr = 10'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic extTickPin = 1'b0;
  logic dirA = 1'b1;
  logic [31:0] prdata, rd, c0;
  logic pready, pslverr, waveA, ownA, waveB, ownB, irq, pinA, pinB, err, lastA, lastB, still;
  logic [1:0] lowBits = 2'h0;
  logic [3:0] m;
  logic [1:0] code, cb;
  int err_total = 0;
  int check_count = 0;
  int seed = 74300;
  int highA, highB, togA, togB, cmp, p, e;
  logic [3:0] tMode [15] = '{4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5, 4'h5, 4'hE, 4'h5, 4'hF,
    4'h1, 4'h1, 4'h8, 4'h1, 4'h9};
  logic [1:0] tCode [15] = '{2'h1, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h3, 2'h2, 2'h1, 2'h1,
    2'h2, 2'h3, 2'h2, 2'h1, 2'h1};
  int tCmp [15] = '{0, 0, 0, 0, 0, 255, 255, 0, 0, 255, 0, 0, 0, 0, 255};
  int tShift [6] = '{0, 0, 3, 6, 8, 10};

  always #20 core_clk = ~core_clk;
  // free-running external tick source, one edge every 8 cycles
  always begin
    repeat (8) @(posedge core_clk);
    extTickPin <= ~extTickPin;
  end

  tw_timer i_dut (.core_clk(core_clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .extTickPin(extTickPin), .chanAWaveOut(waveA), .chanAPinOwned(ownA),
    .chanBWaveOut(waveB), .chanBPinOwned(ownB), .irq(irq));
  tw_pin_load i_loadA (.owned(ownA), .wave(waveA), .dirOut(dirA), .pinLevel(pinA));
  tw_pin_load i_loadB (.owned(ownB), .wave(waveB), .dirOut(1'b1), .pinLevel(pinB));

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    paddr <= {idx, lowBits};
    pwrite <= wr;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic measure(input int n);
    highA = 0;
    highB = 0;
    togA = 0;
    togB = 0;
    repeat (n) begin
      lastA = waveA;
      lastB = waveB;
      @(posedge core_clk);
      highA += int'(waveA);
      highB += int'(waveB);
      togA += int'(waveA !== lastA);
      togB += int'(waveB !== lastB);
    end
  endtask : measure

  function automatic int period(input logic [3:0] md, input int c);
    if (md == MODE_CTC_CMP) return c + 1;
    return (md inside {MODE_PC_8, MODE_PFC_CAP, MODE_PFC_CMP}) ? 510 : 256;
  endfunction : period

  // high cycles over two periods of the waveform
  function automatic int exp_high(input logic [3:0] md, input logic [1:0] cd, input int c,
    input int pp);
    int h;
    if (cd == OM_TOGGLE) return pp;
    if (md == MODE_CTC_CMP) h = (cd == OM_SET) ? pp : 0;
    else if (pp == 510) h = (cd == OM_CLEAR) ? 2 * c : pp - 2 * c;
    else if (c == 255) h = (cd == OM_CLEAR) ? pp : 0;
    else h = (cd == OM_CLEAR) ? c : pp - c;
    return 2 * h;
  endfunction : exp_high

  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (100000) @(posedge core_clk);
    err_total++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    repeat (5) @(posedge core_clk);
    reset_n <= 1'b1;
    apb(1'b0, IDX_CTRL_A, 32'h0);
    check(rd, {24'h0, CTRL_A_RESET}, "ctrl A reset");
    apb(1'b1, IDX_CTRL_A, 32'hFF);
    apb(1'b0, IDX_CTRL_A, 32'h0);
    check(rd, {24'h0, CTRL_A_WRITE_MASK}, "ctrl A bits");
    apb(1'b0, 8'h3F, 32'h0);
    check({err, rd[30:0]}, 32'h80000000, "unmapped");
    lowBits = 2'h1;
    apb(1'b1, IDX_CMP_A, 32'h1234);
    lowBits = 2'h0;
    check({31'h0, err}, 32'h1, "misaligned");
    apb(1'b1, IDX_IRQ_STATUS, 32'hFF);
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h0, "status read only");
    // tick rate per source over a fixed span of 2048 cycles
    apb(1'b1, IDX_CTRL_A, 32'h0);
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, IDX_CTRL_B, 32'(s));
      apb(1'b0, IDX_COUNT, 32'h0);
      c0 = rd;
      repeat (2045) @(posedge core_clk);
      apb(1'b0, IDX_COUNT, 32'h0);
      e = (s == 0) ? 0 : (s > 5) ? 128 : (2048 >> tShift[s]);
      check((rd - c0) & 32'hFFFF, 32'(e), "ticks");
    end
    apb(1'b1, IDX_CAPTURE, 32'h00FF);
    for (int i = 0; i < 15; i++) begin
      m = tMode[i];
      code = tCode[i];
      cmp = (tCmp[i] != 0) ? tCmp[i] : 1 + ($unsigned($random(seed)) % 254);
      cb = code;
      still = code == OM_TOGGLE && m inside {MODE_FAST_8, MODE_PC_8};
      dirA <= 1'($random(seed));
      apb(1'b1, IDX_CTRL_B, 32'h0);
      apb(1'b1, IDX_CTRL_A, {24'h0, code, cb, 2'h0, m[1:0]});
      apb(1'b1, IDX_CMP_A, 32'(cmp));
      apb(1'b1, IDX_CMP_B, 32'(cmp));
      apb(1'b1, IDX_COUNT, 32'h0);
      apb(1'b1, IDX_CTRL_B, {27'h0, m[3:2], TS_DIV1});
      p = period(m, cmp);
      repeat (2 * p) @(posedge core_clk);
      measure(2 * p);
      check({31'h0, ownA}, {31'h0, !still}, "owner A");
      check({31'h0, ownB}, {31'h0, !still}, "owner B");
      check({31'h0, pinA}, {31'h0, (dirA && !still) ? waveA : 1'b1}, "pin A");
      check({31'h0, pinB}, {31'h0, still ? 1'b1 : waveB}, "pin B");
      if (still) begin
        check(togA, 0, "still A");
      end else begin
        check(highA, exp_high(m, code, cmp, p), "high A");
      end
      if (code == OM_TOGGLE && m != MODE_CTC_CMP) check(togB, 0, "still B");
      else check(highB, exp_high(m, cb, cmp, p), "high B");
    end
    // counter write blocks the match on the following tick
    apb(1'b1, IDX_CTRL_B, 32'h0);
    cmp = 100 + ($unsigned($random(seed)) % 100);
    apb(1'b1, IDX_CTRL_A, {24'h0, OM_TOGGLE, 6'h0});
    apb(1'b1, IDX_CMP_A, 32'(cmp));
    apb(1'b1, IDX_IRQ_ENABLE, 32'h2);
    apb(1'b1, IDX_IRQ_CLEAR, 32'h7);
    apb(1'b1, IDX_COUNT, 32'hFFF0);
    apb(1'b1, IDX_CTRL_B, {29'h0, TS_DIV1});
    repeat (20) @(posedge core_clk);
    apb(1'b1, IDX_CTRL_B, 32'h0);
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h1, "overflow");
    apb(1'b1, IDX_IRQ_CLEAR, 32'h7);
    for (int k = 0; k < 2; k++) begin
      apb(1'b1, IDX_CTRL_B, 32'h0);
      lastA = waveA;
      apb(1'b1, IDX_COUNT, 32'(cmp - 5 * k));
      apb(1'b1, IDX_CTRL_B, {29'h0, TS_DIV1});
      repeat (20) @(posedge core_clk);
      check({31'h0, irq}, 32'(k), "match irq");
      check({31'h0, waveA ^ lastA}, 32'(k), "toggle");
    end
    apb(1'b1, IDX_CTRL_B, 32'h0);
    apb(1'b1, IDX_IRQ_ENABLE, 32'h0);
    check({31'h0, irq}, 32'h0, "masked");
    apb(1'b0, IDX_IRQ_STATUS, 32'h0);
    check(rd, 32'h2, "sticky");
    apb(1'b1, IDX_IRQ_ENABLE, 32'h2);
    apb(1'b1, IDX_IRQ_CLEAR, 32'h2);
    check({31'h0, irq}, 32'h0, "cleared");
    end_sim();
  end
endmodule : timer16_waveform_mode_control_tb
`default_nettype wire
